// >>> bench/host_agent.sv
// Host processor model that drives the slave port pins from the far side
`timescale 1ns/1ps
`default_nettype none
module host_agent
  import pslv_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic [7:0]           host_d_out,
  input  wire logic                 host_d_oe_n,
  output var  pslv_pkg::host_pins_t pins
);
  // ************************************************************
  // Pin transfers
  // ************************************************************
  initial pins = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, a: 2'b00, d: 8'h00};

  // Strobes and gaps run well past four clocks: the slave sees pins through two flops
  task automatic wr_byte(input logic [1:0] sa, input logic [7:0] sd);
    @(posedge clk);
    pins <= '{cs: 1'b1, rd: 1'b0, wr: 1'b1, a: sa, d: sd};
    repeat (5) @(posedge clk);
    pins.wr <= 1'b0;
    repeat (5) @(posedge clk);
    pins <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, a: sa, d: ~sd};
    repeat (5) @(posedge clk);
  endtask : wr_byte

  // Data lines released by the host carry the inverse of the last value, never a stale copy
  task automatic rd_byte(input logic [1:0] sa, output logic [7:0] q, output logic oe_n);
    @(posedge clk);
    pins <= '{cs: 1'b1, rd: 1'b1, wr: 1'b0, a: sa, d: ~pins.d};
    repeat (6) @(posedge clk);
    q = host_d_out;
    oe_n = host_d_oe_n;
    pins.rd <= 1'b0;
    repeat (5) @(posedge clk);
    pins.cs <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : rd_byte
endmodule : host_agent
`default_nettype wire

// >>> bench/parallel_port_slave_buffers_pins_test.sv
// Self-checking bench for the slave port buffers, status flags and pin enables
`timescale 1ns/1ps
`default_nettype none
module parallel_port_slave_buffers_pins_test
  import pslv_pkg::*;
;
  logic        clk;
  logic        srst;
  reg_req_t    req;
  logic [15:0] rdata;
  logic [15:0] pin_is_port;
  logic [7:0]  host_d_out;
  logic        host_d_oe_n;
  logic        threshold_ttl;
  logic        irq;
  host_pins_t  host_in;
  int          err_count;
  int          n_tests;
  int          seed;
  logic [15:0] exp_q[$];
  logic        rd_d;
  logic [7:0]  b[4];
  logic [7:0]  q;
  logic        oe_n;
  logic [15:0] v;
  logic [15:0] pe[4];

  pslv_buffers dut (.clk(clk), .srst(srst), .req(req), .rdata(rdata), .host_in(host_in),
    .host_d_out(host_d_out), .host_d_oe_n(host_d_oe_n), .pin_is_port(pin_is_port),
    .threshold_ttl(threshold_ttl), .irq(irq));
  host_agent hm (.clk(clk), .host_d_out(host_d_out), .host_d_oe_n(host_d_oe_n), .pins(host_in));

  // ************************************************************
  // Clock, compare and bus tasks
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic close_out();
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(exp);
    @(posedge clk);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b0};
  endtask : rd_reg

  // Read data stand only in the cycle after the strobe, so the watcher looks there alone
  always @(posedge clk) begin
    rd_d <= req.rd;
    if (rd_d === 1'b1) cmp(rdata, exp_q.pop_front());
  end

  initial begin
    #200000;
    err_count++;
    close_out();
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    seed = 64;
    err_count = 0;
    n_tests = 0;
    srst = 1'b1;
    req = '0;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_reg(ADDR_STATUS, 16'h008F);
    rd_reg(ADDR_PIN_ENABLE, PIN_ENABLE_RST);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, 16'h0000);
    pe = '{16'hC000, 16'h3FFC, 16'h0003, 16'h0000};
    pe[3] = 16'($random(seed));
    for (int i = 0; i < 4; i++) begin
      wr_reg(ADDR_PIN_ENABLE, pe[i]);
      rd_reg(ADDR_PIN_ENABLE, pe[i]);
      repeat (3) @(posedge clk);
      cmp(pin_is_port, pe[i]);
    end
    wr_reg(ADDR_PAD_CFG, 16'h0001);
    rd_reg(ADDR_PAD_CFG, 16'h0001);
    repeat (3) @(posedge clk);
    cmp({15'h0000, threshold_ttl}, 16'h0001);
    wr_reg(ADDR_PIN_ENABLE, 16'hFFFF);
    hm.wr_byte(2'b00, 8'h5A);
    rd_reg(ADDR_STATUS, 16'h008F);
    wr_reg(ADDR_CONTROL, 16'h000D);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($random(seed));
      hm.wr_byte(2'(i), b[i]);
      v = 16'(((1 << (i + 1)) - 1) << 8) | 16'h008F | ((i == 3) ? 16'h8000 : 16'h0000);
      rd_reg(ADDR_STATUS, v);
    end
    hm.wr_byte(2'b01, ~b[1]);
    rd_reg(ADDR_STATUS, 16'hCF8F);
    rd_reg(ADDR_IN_WORD1, {b[1], b[0]});
    rd_reg(ADDR_STATUS, 16'h4C8F);
    rd_reg(ADDR_IN_WORD2, {b[3], b[2]});
    rd_reg(ADDR_STATUS, 16'h408F);
    wr_reg(ADDR_STATUS, 16'h0000);
    rd_reg(ADDR_STATUS, 16'h008F);
    v = 16'($random(seed));
    wr_reg(ADDR_OUT_WORD1, v);
    rd_reg(ADDR_STATUS, 16'h000C);
    for (int i = 0; i < 2; i++) begin
      hm.rd_byte(2'(i), q, oe_n);
      cmp({8'h00, q}, {8'h00, (i == 1) ? v[15:8] : v[7:0]});
      cmp({15'h0000, oe_n}, 16'h0000);
    end
    cmp({15'h0000, host_d_oe_n}, 16'h0001);
    rd_reg(ADDR_STATUS, 16'h008F);
    hm.rd_byte(2'b10, q, oe_n);
    rd_reg(ADDR_STATUS, 16'h00CF);
    wr_reg(ADDR_STATUS, 16'h0000);
    rd_reg(ADDR_STATUS, 16'h008F);
    rd_reg(ADDR_IRQ_STATUS, 16'h0007);
    cmp({15'h0000, irq}, 16'h0000);
    wr_reg(ADDR_IRQ_MASK, 16'h0001);
    repeat (3) @(posedge clk);
    cmp({15'h0000, irq}, 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 16'h0001);
    rd_reg(ADDR_IRQ_STATUS, 16'h0006);
    repeat (3) @(posedge clk);
    cmp({15'h0000, irq}, 16'h0000);
    wr_reg(ADDR_IRQ_MASK, 16'h0006);
    repeat (3) @(posedge clk);
    cmp({15'h0000, irq}, 16'h0001);
    wr_reg(ADDR_IRQ_STATUS, 16'h0006);
    repeat (3) @(posedge clk);
    cmp({15'h0000, irq}, 16'h0000);
    repeat (4) @(posedge clk);
    close_out();
  end
endmodule : parallel_port_slave_buffers_pins_test
`default_nettype wire

// >>> hw/pslv_buffers.sv
// Parallel slave port: addressable byte buffers, status flags and pin function enables
//
// Behaviour
// - Top enable gives pins 15:14 to port
// - Middle enables give address pins 13:2
// - Low enable gives pins 1:0 to port
// - All-full flag only when every slot full
// - Host write to full slot sets overflow
// - Slot full set by host write, cleared by read
// - All-empty flag only when every slot empty
// - Host read of empty slot sets underflow
// - Slot empty cleared by write, set on host read
// - Host low address lines select byte slot
// - Reset: empty flags one, others zero
// - Mode one is enhanced addressable slave port
// - Interrupt mode three fires on slot three
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module pslv_buffers
  import pslv_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 srst,
  input  wire pslv_pkg::reg_req_t   req,
  output logic [15:0]               rdata,
  input  wire pslv_pkg::host_pins_t host_in,
  output logic [7:0]                host_d_out,
  output logic                      host_d_oe_n,
  output logic [15:0]               pin_is_port,
  output logic                      threshold_ttl,
  output logic                      irq
);
  import pslv_pkg::*;

  // ************************************************************
  // Host pin synchronisers
  // ************************************************************
  host_pins_t pin_s1_r;
  host_pins_t pin_s2_r;
  host_pins_t pin_prev_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_r   <= '0;
      pin_s2_r   <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_s1_r   <= host_in;
      pin_s2_r   <= pin_s1_r;
      pin_prev_r <= pin_s2_r;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [15:0] pin_function_enable_r;
  logic        threshold_r;
  logic [1:0]  mode_r;
  logic [1:0]  irq_sel_r;
  logic [2:0]  irq_mask_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_function_enable_r <= PIN_ENABLE_RST;
      threshold_r           <= 1'b0;
      mode_r                <= MODE_LEGACY;
      irq_sel_r             <= 2'b00;
      irq_mask_r            <= 3'b000;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_PIN_ENABLE: pin_function_enable_r <= req.wdata;
        ADDR_PAD_CFG:    threshold_r <= req.wdata[0];
        ADDR_CONTROL: begin
          mode_r    <= req.wdata[CTL_MODE_LO +: 2];
          irq_sel_r <= req.wdata[CTL_IRQSEL_LO +: 2];
        end
        ADDR_IRQ_MASK:   irq_mask_r <= req.wdata[2:0];
        default: ;
      endcase
    end
  end

  // ************************************************************
  // Pin functions
  // ************************************************************
  // Pins stay general port I/O while their enable is clear
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_is_port   <= 16'h0000;
      threshold_ttl <= 1'b0;
    end else begin
      pin_is_port[15:14] <= pin_function_enable_r[15:14];
      pin_is_port[13:2]  <= pin_function_enable_r[13:2];
      pin_is_port[1:0]   <= pin_function_enable_r[1:0];
      threshold_ttl      <= threshold_r;
    end
  end

  // ************************************************************
  // Host access decode
  // ************************************************************
  logic       enhanced;
  logic       host_sel;
  logic       host_wr_ev;
  logic       host_rd_ev;
  logic [1:0] host_slot;
  assign enhanced   = (mode_r == MODE_ENHANCED);
  assign host_sel   = enhanced && pin_s2_r.cs && pin_function_enable_r[0] && pin_function_enable_r[1];
  // Write strobe falling edge ends the cycle; data and address are settled by then; reads count on the rising edge of rd
  assign host_wr_ev = host_sel && pin_prev_r.wr && !pin_s2_r.wr;
  assign host_rd_ev = host_sel && pin_s2_r.rd && !pin_prev_r.rd;
  assign host_slot  = pin_s2_r.a;

  // ************************************************************
  // Byte buffers and flags
  // ************************************************************
  logic [7:0] out_buf_r [4];
  logic [7:0] in_buf_r  [4];
  logic [3:0] in_full_r;
  logic [3:0] out_empty_r;
  logic       in_overflow_r;
  logic       out_underflow_r;
  logic [3:0] sw_out_wr;
  logic [3:0] sw_in_rd;
  always_comb begin
    sw_out_wr = 4'h0;
    sw_in_rd  = 4'h0;
    if (req.wr && req.addr == ADDR_OUT_WORD1) sw_out_wr[1:0] = 2'b11;
    if (req.wr && req.addr == ADDR_OUT_WORD2) sw_out_wr[3:2] = 2'b11;
    if (req.rd && req.addr == ADDR_IN_WORD1)  sw_in_rd[1:0]  = 2'b11;
    if (req.rd && req.addr == ADDR_IN_WORD2)  sw_in_rd[3:2]  = 2'b11;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < 4; i++) begin
        out_buf_r[i] <= 8'h00;
        in_buf_r[i]  <= 8'h00;
      end
    end else begin
      if (req.wr && req.addr == ADDR_OUT_WORD1) begin
        out_buf_r[0] <= req.wdata[7:0];
        out_buf_r[1] <= req.wdata[15:8];
      end
      if (req.wr && req.addr == ADDR_OUT_WORD2) begin
        out_buf_r[2] <= req.wdata[7:0];
        out_buf_r[3] <= req.wdata[15:8];
      end
      // A write to a full slot is dropped; the unread byte is kept
      if (host_wr_ev && !in_full_r[host_slot]) in_buf_r[host_slot] <= pin_s2_r.d;
    end
  end

  // Hardware set wins over a same-cycle software clear or read
  always_ff @(posedge clk) begin
    if (srst) begin
      in_full_r   <= IN_FULL_RST;
      out_empty_r <= OUT_EMPTY_RST;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (host_wr_ev && host_slot == 2'(i)) in_full_r[i] <= 1'b1;
        else if (sw_in_rd[i]) in_full_r[i] <= 1'b0;
        if (host_rd_ev && host_slot == 2'(i)) out_empty_r[i] <= 1'b1;
        else if (sw_out_wr[i]) out_empty_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      in_overflow_r   <= 1'b0;
      out_underflow_r <= 1'b0;
    end else begin
      if (host_wr_ev && in_full_r[host_slot]) in_overflow_r <= 1'b1;
      else if (req.wr && req.addr == ADDR_STATUS && !req.wdata[ST_IN_OVERFLOW]) in_overflow_r <= 1'b0;
      if (host_rd_ev && out_empty_r[host_slot]) out_underflow_r <= 1'b1;
      else if (req.wr && req.addr == ADDR_STATUS && !req.wdata[ST_OUT_UNDERFLOW]) out_underflow_r <= 1'b0;
    end
  end

  logic in_all_full;
  logic out_all_empty;
  assign in_all_full   = &in_full_r;
  assign out_all_empty = &out_empty_r;

  // ************************************************************
  // Host data drive
  // ************************************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      host_d_out  <= 8'h00;
      host_d_oe_n <= 1'b1;
    end else begin
      host_d_out  <= out_buf_r[host_slot];
      host_d_oe_n <= !(host_sel && pin_s2_r.rd);
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  logic [2:0] irq_status_r;
  logic [2:0] irq_set;
  assign irq_set[IRQ_ACCESS]    = (irq_sel_r == IRQSEL_SLOT3) && (host_wr_ev || host_rd_ev)
                                  && host_slot == LAST_SLOT;
  assign irq_set[IRQ_OVERFLOW]  = host_wr_ev && in_full_r[host_slot];
  assign irq_set[IRQ_UNDERFLOW] = host_rd_ev && out_empty_r[host_slot];
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_status_r <= 3'b000;
      irq          <= 1'b0;
    end else begin
      irq_status_r <= irq_set | (irq_status_r &
                      ~((req.wr && req.addr == ADDR_IRQ_STATUS) ? req.wdata[2:0] : 3'b000));
      irq          <= |(irq_status_r & irq_mask_r);
    end
  end

  // ************************************************************
  // Register read
  // ************************************************************
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[ST_IN_ALL_FULL]            = in_all_full;
    status_word[ST_IN_OVERFLOW]            = in_overflow_r;
    status_word[ST_IN_SLOT_LO +: 4]        = in_full_r;
    status_word[ST_OUT_ALL_EMPTY]          = out_all_empty;
    status_word[ST_OUT_UNDERFLOW]          = out_underflow_r;
    status_word[ST_OUT_SLOT_LO +: 4]       = out_empty_r;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 16'h0000;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_PIN_ENABLE: rdata <= pin_function_enable_r;
        ADDR_STATUS:     rdata <= status_word;
        ADDR_PAD_CFG:    rdata <= {15'h0000, threshold_r};
        ADDR_CONTROL:    rdata <= {12'h000, irq_sel_r, mode_r};
        ADDR_OUT_WORD1:  rdata <= {out_buf_r[1], out_buf_r[0]};
        ADDR_OUT_WORD2:  rdata <= {out_buf_r[3], out_buf_r[2]};
        ADDR_IN_WORD1:   rdata <= {in_buf_r[1], in_buf_r[0]};
        ADDR_IN_WORD2:   rdata <= {in_buf_r[3], in_buf_r[2]};
        ADDR_IRQ_STATUS: rdata <= {13'h0000, irq_status_r};
        ADDR_IRQ_MASK:   rdata <= {13'h0000, irq_mask_r};
        default:         rdata <= 16'h0000;
      endcase
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  AST_PIN_TOP: assert property (##1 pin_is_port[15:14] == $past(pin_function_enable_r[15:14]))
    else $error("Top pin function does not follow enable");
  AST_PIN_MID: assert property (##1 pin_is_port[13:2] == $past(pin_function_enable_r[13:2]))
    else $error("Middle pin function does not follow enable");
  AST_PIN_LOW: assert property (##1 pin_is_port[1:0] == $past(pin_function_enable_r[1:0]))
    else $error("Low pin function does not follow enable");
  AST_ALL_FULL: assert property (in_all_full == (in_full_r == 4'hF))
    else $error("All-full flag wrong");
  AST_OVERFLOW: assert property (host_wr_ev && in_full_r[host_slot] |=> in_overflow_r)
    else $error("Overflow not flagged");
  AST_SLOT_FULL: assert property (host_wr_ev |=> in_full_r[$past(host_slot)])
    else $error("Slot full not set by host write");
  AST_ALL_EMPTY: assert property (out_all_empty == (out_empty_r == 4'hF))
    else $error("All-empty flag wrong");
  AST_UNDERFLOW: assert property (host_rd_ev && out_empty_r[host_slot] |=> out_underflow_r)
    else $error("Underflow not flagged");
  AST_SLOT_EMPTY: assert property (sw_out_wr[0] && !(host_rd_ev && host_slot == 2'b00) |=> !out_empty_r[0])
    else $error("Slot empty not cleared by write");
  AST_SLOT_SEL: assert property (host_wr_ev && !in_full_r[host_slot] |=> in_buf_r[$past(host_slot)] == $past(pin_s2_r.d))
    else $error("Host byte stored in wrong slot");
  AST_RESET: assert property (disable iff (1'b0) $past(srst) |-> out_empty_r == 4'hF && in_full_r == 4'h0 && !in_overflow_r)
    else $error("Flags wrong after reset");
  AST_MODE: assert property (!enhanced |-> !host_wr_ev && !host_rd_ev)
    else $error("Host access taken outside enhanced mode");
  AST_IRQ3: assert property (irq_set[IRQ_ACCESS] |=> irq_status_r[IRQ_ACCESS])
    else $error("Slot three access interrupt lost");
  // Sticky flags must survive every cycle without a status write
  AST_OVF_HOLD: assert property (in_overflow_r && !(req.wr && req.addr == ADDR_STATUS) |=> in_overflow_r)
    else $error("Overflow flag lost without software clear");
  AST_UNF_HOLD: assert property (out_underflow_r && !(req.wr && req.addr == ADDR_STATUS) |=> out_underflow_r)
    else $error("Underflow flag lost without software clear");
  AST_SLOT_READ: assert property (sw_in_rd[0] && !(host_wr_ev && host_slot == 2'b00) |=> !in_full_r[0])
    else $error("Slot full not cleared by software read");
  AST_EMPTY_SET: assert property (host_rd_ev |=> out_empty_r[$past(host_slot)])
    else $error("Slot empty not set by host read");

  COV_HOST_WR: cover property (host_wr_ev ##[1:50] sw_in_rd[0]);
  COV_OVERFLOW: cover property (in_all_full ##[1:20] in_overflow_r);
  COV_UNDERFLOW: cover property (out_underflow_r);
  COV_IRQ: cover property (irq);
endmodule : pslv_buffers
`default_nettype wire

// >>> hw/pslv_pkg.sv
// Package: register map, field positions and types of the parallel slave port buffers
package pslv_pkg;
  // ************************************************************
  // Register indices (plain port addresses)
  // ************************************************************
  localparam logic [3:0]  ADDR_PIN_ENABLE  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS      = 4'h1;
  localparam logic [3:0]  ADDR_PAD_CFG     = 4'h2;
  localparam logic [3:0]  ADDR_CONTROL     = 4'h3;
  localparam logic [3:0]  ADDR_OUT_WORD1   = 4'h4;
  localparam logic [3:0]  ADDR_OUT_WORD2   = 4'h5;
  localparam logic [3:0]  ADDR_IN_WORD1    = 4'h6;
  localparam logic [3:0]  ADDR_IN_WORD2    = 4'h7;
  localparam logic [3:0]  ADDR_IRQ_STATUS  = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK    = 4'h9;
  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ST_IN_ALL_FULL   = 15;
  localparam int ST_IN_OVERFLOW   = 14;
  localparam int ST_IN_SLOT_LO    = 8;
  localparam int ST_OUT_ALL_EMPTY = 7;
  localparam int ST_OUT_UNDERFLOW = 6;
  localparam int ST_OUT_SLOT_LO   = 0;
  localparam int CTL_MODE_LO      = 0;
  localparam int CTL_IRQSEL_LO    = 2;
  localparam int IRQ_ACCESS       = 0;
  localparam int IRQ_OVERFLOW     = 1;
  localparam int IRQ_UNDERFLOW    = 2;
  // ************************************************************
  // Reset values and encodings
  // ************************************************************
  localparam logic [15:0] PIN_ENABLE_RST  = 16'h0000;
  localparam logic [3:0]  IN_FULL_RST     = 4'h0;
  localparam logic [3:0]  OUT_EMPTY_RST   = 4'hF;
  localparam logic [1:0]  MODE_LEGACY     = 2'b00;
  localparam logic [1:0]  MODE_ENHANCED   = 2'b01;
  localparam logic [1:0]  IRQSEL_SLOT3    = 2'b11;
  localparam logic [1:0]  LAST_SLOT       = 2'b11;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [1:0] a;
    logic [7:0] d;
  } host_pins_t;
endpackage : pslv_pkg
